// file: hdl/sil_top.sv
// Operation
// - elevator pretransfer starts pending; timer end clears
// - pending countdown shown in whole seconds
// - idle healthy: heartbeat blinks at half hertz
// - active event code replaces heartbeat until acknowledged
// - source one lamp mirrors source one ok
// - source two lamp mirrors source two ok
// - start A steady commanded, blinks during delay
// - start B likewise, genset mode only
// - retransfer lamp: relay steady, delay blinks
// - transfer lamp: relay steady, delay blinks
// - sync lamp one-second blink, max 120 s
// - neutral hold delay blinks its lamp
// - exerciser lamp: enabled steady, period blinks
// - module switch toggles exerciser; bus commands too
// - disabled exerciser: no periods, lamp off
// - code flashed digitwise with gaps and rest
// - acknowledged events go into 50-entry history
// - history fully readable over the bus
// - active fault blinks asterisk until acknowledged
`timescale 1ns/1ns
`include "sil_cfg.svh"
module sil_top #(
   parameter int HALF_SEC_CYC = `SIL_CLK_HZ / 1000 * `SIL_HALF_SEC_MS
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic ELEV_PRETRANSFER,
   input wire logic SRC1_GOOD,
   input wire logic SRC2_GOOD,
   input wire logic START_A_CMD,
   input wire logic START_A_DELAY,
   input wire logic START_B_CMD,
   input wire logic START_B_DELAY,
   input wire logic RETRANSFER_RELAY,
   input wire logic RETRANSFER_DELAY,
   input wire logic TRANSFER_RELAY,
   input wire logic FORWARD_TRANSFER_DELAY,
   input wire logic INPHASE_ACTIVE,
   input wire logic NEUTRAL_HOLD_DELAY,
   input wire logic EXER_PERIOD,
   input wire logic EXER_SWITCH,
   input wire logic RESET_SWITCH,
   input wire logic [5:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic LED_STATUS,
   output logic SOURCE_ONE_OK_LAMP,
   output logic SOURCE_TWO_OK_LAMP,
   output logic LED_START_A,
   output logic LED_START_B,
   output logic LED_RETRANSFER,
   output logic LED_TRANSFER,
   output logic LED_SYNC,
   output logic LED_NEUTRAL,
   output logic LED_EXER,
   output logic ASTERISK,
   output logic PEND_ACTIVE,
   output logic [9:0] PEND_SECS,
   output logic EXER_ALLOW
);
   import sil_pkg::*;

   ////////////////////////////////////////////////////////////////
   // pin synchronisers: every pin passes two flops
   logic [15:0] sync1_r; // first stage, read only by stage two
   logic [15:0] sync2_r; // second stage, safe to use
   wire [15:0] pins = {ELEV_PRETRANSFER, SRC1_GOOD, SRC2_GOOD, START_A_CMD,
      START_A_DELAY, START_B_CMD, START_B_DELAY, RETRANSFER_RELAY,
      RETRANSFER_DELAY, TRANSFER_RELAY, FORWARD_TRANSFER_DELAY, INPHASE_ACTIVE,
      NEUTRAL_HOLD_DELAY, EXER_PERIOD, EXER_SWITCH, RESET_SWITCH};
   wire elev_s, src1_s, src2_s, sta_cmd_s, sta_dly_s, stb_cmd_s, stb_dly_s;
   wire rtx_rly_s, rtx_dly_s, xfr_rly_s, xfr_dly_s, inph_s, ntl_dly_s;
   wire exper_s, exsw_s, rstsw_s;
   assign {elev_s, src1_s, src2_s, sta_cmd_s, sta_dly_s, stb_cmd_s, stb_dly_s,
      rtx_rly_s, rtx_dly_s, xfr_rly_s, xfr_dly_s, inph_s, ntl_dly_s,
      exper_s, exsw_s, rstsw_s} = sync2_r;

   // both stages clear at reset so no false edge is seen
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         sync1_r <= 16'h0000;
         sync2_r <= 16'h0000;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////
   // edge detectors on synchronised switches and pretransfer
   logic elev_d_r; // previous pretransfer level
   logic exsw_d_r; // previous exerciser switch level
   logic rstsw_d_r; // previous reset switch level
   wire elev_rise = elev_s & ~elev_d_r;
   wire exsw_rise = exsw_s & ~exsw_d_r;
   wire ack = rstsw_s & ~rstsw_d_r; // operator acknowledge

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         elev_d_r <= 1'h0;
         exsw_d_r <= 1'h0;
         rstsw_d_r <= 1'h0;
      end else begin
         elev_d_r <= elev_s;
         exsw_d_r <= exsw_s;
         rstsw_d_r <= rstsw_s;
      end
   end

   ////////////////////////////////////////////////////////////////
   // blink time base: half-second tick, 1 s and 2 s square waves
   logic [24:0] tb_cnt_r; // cycles within half second
   logic phase_r; // second half-tick of each second
   logic blink_1s_r; // period one second
   logic blink_half_r; // period two seconds, half hertz
   wire half_tick = (tb_cnt_r == 25'(HALF_SEC_CYC - 1));
   wire sec_tick = half_tick & phase_r;

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         tb_cnt_r <= 25'h000_0000;
         phase_r <= 1'h0;
         blink_1s_r <= 1'h0;
         blink_half_r <= 1'h0;
      end else begin
         tb_cnt_r <= half_tick ? 25'h000_0000 : 25'(tb_cnt_r + 25'h1);
         if (half_tick) begin
            phase_r <= ~phase_r;
            blink_1s_r <= ~blink_1s_r;
         end
         if (sec_tick) blink_half_r <= ~blink_half_r;
      end
   end

   ////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, answer in the second cycle
   logic wait_r; // waitrequest, high when idle
   logic [31:0] rdata_r; // registered read data
   logic exer_en_r; // exerciser enable
   logic genset_r; // genset-to-genset configuration
   logic [9:0] pdelay_r; // transfer_pending_delay in seconds
   logic [5:0] hsel_r; // history entry age selector
   wire req = AVS_READ | AVS_WRITE;
   wire [3:0] word = AVS_ADDRESS[5:2];
   wire wr_go = AVS_WRITE & ~wait_r; // write takes effect here
   wire wait_nxt = ~(req & wait_r);
   wire wr_ctrl = wr_go & (word == `SIL_OFS_CTRL);
   wire raise = wr_go & (word == `SIL_OFS_RAISE);
   wire wr_pdelay = wr_go & (word == `SIL_OFS_PDELAY);
   wire wr_hsel = wr_go & (word == `SIL_OFS_HSEL);

   ////////////////////////////////////////////////////////////////
   // active event slot and acknowledge
   logic act_valid_r; // an event is being annunciated
   sil_evt_t act_r; // fault flag and bcd code
   // a raise in the ack cycle is taken, so nothing is lost
   wire take = raise & (~act_valid_r | ack);
   wire log_it = ack & act_valid_r; // acknowledged event is logged

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         act_valid_r <= 1'h0;
         act_r <= 17'h0_0000;
      end else if (take) begin
         act_valid_r <= 1'h1;
         act_r <= AVS_WRITEDATA[16:0];
      end else if (ack) begin
         act_valid_r <= 1'h0; // flashing ends on acknowledge
      end
   end

   ////////////////////////////////////////////////////////////////
   // event history: circular, newest at age zero
   sil_evt_t hist_mem [0:`SIL_HIST_DEPTH-1]; // history store
   logic [5:0] wptr_r; // next slot to write
   logic [5:0] hcnt_r; // entries held, saturates at depth
   wire wrap = (wptr_r == 6'(`SIL_HIST_DEPTH - 1));
   wire [6:0] age_sum = 7'({1'b0, wptr_r} + 7'(`SIL_HIST_DEPTH) - 7'h1 - {1'b0, hsel_r});
   wire [5:0] hslot = (age_sum >= 7'(`SIL_HIST_DEPTH)) ? 6'(age_sum - 7'(`SIL_HIST_DEPTH)) : age_sum[5:0];
   wire hvalid = (hsel_r < hcnt_r);

   // storage has no reset; only entries below the count are shown
   always_ff @(posedge CLK) begin
      if (log_it) hist_mem[wptr_r] <= act_r;
   end

   // pointer wraps, so a full store overwrites its oldest entry
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         wptr_r <= 6'h00;
         hcnt_r <= 6'h00;
      end else if (log_it) begin
         wptr_r <= wrap ? 6'h00 : 6'(wptr_r + 6'h1);
         if (hcnt_r != 6'(`SIL_HIST_DEPTH)) hcnt_r <= 6'(hcnt_r + 6'h1);
      end
   end

   ////////////////////////////////////////////////////////////////
   // transfer pending countdown
   logic [9:0] psecs_r; // seconds remaining, zero means idle
   wire [9:0] psecs_nxt = elev_rise ? pdelay_r :
      (sec_tick && psecs_r != 10'h000) ? 10'(psecs_r - 10'h1) : psecs_r;

   // the event lasts exactly as long as the timer runs
   always_ff @(posedge CLK) begin
      if (!NRST) psecs_r <= 10'h000;
      else psecs_r <= psecs_nxt;
   end

   ////////////////////////////////////////////////////////////////
   // sync check second counter, stops at the limit
   logic [6:0] sync_s_r; // seconds the in-phase sensor has been on
   wire sync_live = inph_s & (sync_s_r < `SIL_SYNC_MAX_S);

   always_ff @(posedge CLK) begin
      if (!NRST || !inph_s) sync_s_r <= 7'h00;
      else if (sec_tick && sync_live) sync_s_r <= 7'(sync_s_r + 7'h1);
   end

   ////////////////////////////////////////////////////////////////
   // exerciser enable: switch toggles, bus write overrides
   wire exer_nxt = wr_ctrl ? AVS_WRITEDATA[`SIL_CTRL_EXER] : exsw_rise ? ~exer_en_r : exer_en_r;

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         exer_en_r <= 1'h0;
         genset_r <= 1'h0;
         pdelay_r <= `SIL_PDELAY_RST;
         hsel_r <= 6'h00;
      end else begin
         exer_en_r <= exer_nxt;
         if (wr_ctrl) genset_r <= AVS_WRITEDATA[`SIL_CTRL_GENSET];
         if (wr_pdelay) pdelay_r <= AVS_WRITEDATA[9:0];
         if (wr_hsel) hsel_r <= AVS_WRITEDATA[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////
   // flash-out of the active code
   wire flash_led; // flasher output
   sil_flash u_flash (
      .clk(CLK),
      .nrst(NRST),
      .en(act_valid_r),
      .tick(half_tick),
      .code(act_r[15:0]),
      .led(flash_led)
   );

   ////////////////////////////////////////////////////////////////
   // lamp patterns; timing blink wins over the steady state
   function automatic logic pattern(input logic steady, input logic timing, input logic ph);
      pattern = timing ? ph : steady;
   endfunction

   logic [10:0] lamps_r; // every lamp but the asterisk, registered
   logic asterisk_r; // display fault marker
   logic exer_allow_r; // exercise periods permitted
   wire exer_run = exer_en_r & exper_s; // disabled means no period
   wire status_nxt = act_valid_r ? flash_led : blink_half_r;
   wire [10:0] lamps_nxt = {
      status_nxt,
      src1_s,
      src2_s,
      pattern(sta_cmd_s, sta_dly_s, blink_half_r),
      genset_r & pattern(stb_cmd_s, stb_dly_s, blink_half_r),
      pattern(rtx_rly_s, rtx_dly_s, blink_half_r),
      pattern(xfr_rly_s, xfr_dly_s, blink_half_r),
      sync_live & blink_1s_r,
      ntl_dly_s & blink_half_r,
      exer_en_r & pattern(1'h1, exper_s, blink_half_r)
      , 1'h0};

   // every indicator output leaves from a flop
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         lamps_r <= 11'h000;
         asterisk_r <= 1'h0;
         exer_allow_r <= 1'h0;
      end else begin
         lamps_r <= lamps_nxt;
         asterisk_r <= act_valid_r & act_r[16] & blink_half_r;
         exer_allow_r <= exer_run;
      end
   end

   assign {LED_STATUS, SOURCE_ONE_OK_LAMP, SOURCE_TWO_OK_LAMP, LED_START_A, LED_START_B,
      LED_RETRANSFER, LED_TRANSFER, LED_SYNC, LED_NEUTRAL, LED_EXER} = lamps_r[10:1];
   assign ASTERISK = asterisk_r;
   assign EXER_ALLOW = exer_allow_r;
   assign PEND_SECS = psecs_r;

   ////////////////////////////////////////////////////////////////
   // read mux; unmapped words read zero
   logic pend_r; // pending flag, registered
   wire [31:0] rd_mux =
      (word == `SIL_OFS_CTRL) ? {30'h0000_0000, genset_r, exer_en_r} :
      (word == `SIL_OFS_LAMPS) ? {20'h0_0000, asterisk_r, lamps_r} :
      (word == `SIL_OFS_ACTIVE) ? {act_valid_r, 14'h0000, act_r} :
      (word == `SIL_OFS_PDELAY) ? {22'h00_0000, pdelay_r} :
      (word == `SIL_OFS_PSTAT) ? {pend_r, 21'h00_0000, psecs_r} :
      (word == `SIL_OFS_HSEL) ? {26'h000_0000, hsel_r} :
      (word == `SIL_OFS_HDATA) ? (hvalid ? {1'h1, 14'h0000, hist_mem[hslot]} : 32'h0000_0000) :
      (word == `SIL_OFS_HCOUNT) ? {26'h000_0000, hcnt_r} : 32'h0000_0000;

   // waitrequest drops for exactly one cycle per request
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         wait_r <= 1'h1;
         rdata_r <= 32'h0000_0000;
         pend_r <= 1'h0;
      end else begin
         wait_r <= wait_nxt;
         if (AVS_READ && wait_r) rdata_r <= rd_mux;
         pend_r <= (psecs_nxt != 10'h000);
      end
   end

   assign AVS_WAITREQUEST = wait_r;
   assign AVS_READDATA = rdata_r;
   assign PEND_ACTIVE = pend_r;

   ////////////////////////////////////////////////////////////////
   // checks
   // two synchroniser flops plus the lamp flop: the lamp shows the pin three edges late
   a_src1_follow: assert property (@(posedge CLK) disable iff (!NRST)
      $past(NRST, 3) |-> SOURCE_ONE_OK_LAMP == $past(SRC1_GOOD, 3))
      else $error("source one lamp not following pin");
   a_src2_follow: assert property (@(posedge CLK) disable iff (!NRST)
      $past(NRST, 3) |-> SOURCE_TWO_OK_LAMP == $past(SRC2_GOOD, 3))
      else $error("source two lamp not following pin");
   a_start_a_on: assert property (@(posedge CLK) disable iff (!NRST)
      sta_cmd_s && !sta_dly_s |=> LED_START_A)
      else $error("start A lamp not steady");
   a_start_b_gate: assert property (@(posedge CLK) disable iff (!NRST)
      !genset_r |=> !LED_START_B)
      else $error("start B lamp lit outside genset mode");
   a_pend_start: assert property (@(posedge CLK) disable iff (!NRST)
      elev_rise && pdelay_r != 10'h000 |=> PEND_ACTIVE && PEND_SECS == $past(pdelay_r))
      else $error("pending not started by pretransfer");
   a_pend_nonzero: assert property (@(posedge CLK) disable iff (!NRST)
      PEND_ACTIVE |-> PEND_SECS != 10'h000)
      else $error("pending shown with zero time");
   a_sync_limit: assert property (@(posedge CLK) disable iff (!NRST)
      sync_s_r >= `SIL_SYNC_MAX_S |=> !LED_SYNC)
      else $error("sync lamp past its limit");
   a_exer_off: assert property (@(posedge CLK) disable iff (!NRST)
      !exer_en_r |=> !LED_EXER && !EXER_ALLOW)
      else $error("exerciser active while disabled");
   a_ack_logs: assert property (@(posedge CLK) disable iff (!NRST)
      log_it && hcnt_r < 6'(`SIL_HIST_DEPTH) |=>
      hcnt_r == 6'($past(hcnt_r) + 6'h1) && hist_mem[$past(wptr_r)] == $past(act_r))
      else $error("acknowledged event not logged");
   a_hist_bound: assert property (@(posedge CLK) disable iff (!NRST)
      hcnt_r <= 6'(`SIL_HIST_DEPTH) && wptr_r < 6'(`SIL_HIST_DEPTH))
      else $error("history pointer out of range");
   a_ack_clears: assert property (@(posedge CLK) disable iff (!NRST)
      ack && !raise |=> !act_valid_r ##1 LED_STATUS == $past(blink_half_r))
      else $error("acknowledge did not restore heartbeat");
   a_asterisk_gate: assert property (@(posedge CLK) disable iff (!NRST)
      !act_valid_r |=> !ASTERISK)
      else $error("asterisk without active fault");
endmodule // sil_top

// file: hdl/sil_cfg.svh
`ifndef SIL_CFG_SVH
`define SIL_CFG_SVH
// clock and blink timing
`define SIL_CLK_HZ 20000000
`define SIL_HALF_SEC_MS 500
// sync-check blink limit in seconds
`define SIL_SYNC_MAX_S 7'h78
// history depth in entries
`define SIL_HIST_DEPTH 50
// flash-out pacing in half-second units, and the flash count for a zero digit
`define SIL_GAP_UNITS 4'h3
`define SIL_REST_UNITS 4'h7
`define SIL_ZERO_FLASHES 4'hA
// register word indexes, decoded on address bits 5:2
`define SIL_OFS_CTRL 4'h0
`define SIL_OFS_LAMPS 4'h1
`define SIL_OFS_RAISE 4'h2
`define SIL_OFS_ACTIVE 4'h3
`define SIL_OFS_PDELAY 4'h4
`define SIL_OFS_PSTAT 4'h5
`define SIL_OFS_HSEL 4'h6
`define SIL_OFS_HDATA 4'h7
`define SIL_OFS_HCOUNT 4'h8
// field positions
`define SIL_CTRL_EXER 0
`define SIL_CTRL_GENSET 1
`define SIL_VALID_BIT 31
// reset values
`define SIL_PDELAY_RST 10'h00A
`endif

// file: hdl/sil_pkg.sv
package sil_pkg;
   // bcd fault code, four digits
   typedef logic [15:0] sil_bcd_t;
   // event: fault flag over bcd code
   typedef logic [16:0] sil_evt_t;
   // flash-out sequencer states
   typedef enum logic [2:0] {FL_IDLE, FL_ON, FL_OFF, FL_GAP, FL_REST} sil_fl_state_t;
endpackage

// file: hdl/sil_flash.sv
`timescale 1ns/1ns
`include "sil_cfg.svh"
module sil_flash (
   input wire logic clk,
   input wire logic nrst,
   input wire logic en,
   input wire logic tick,
   input wire sil_pkg::sil_bcd_t code,
   output logic led
);
   import sil_pkg::*;

   ////////////////////////////////////////////////////////////////
   // digit helpers
   function automatic logic [3:0] digit_of(input sil_bcd_t c, input logic [1:0] i);
      digit_of = c[4*i +: 4];
   endfunction

   // zero digit is ten flashes so it stays visible
   function automatic logic [3:0] flashes_of(input logic [3:0] d);
      flashes_of = (d == 4'h0) ? `SIL_ZERO_FLASHES : d;
   endfunction

   // leading zeros are skipped
   function automatic logic [1:0] lead_of(input sil_bcd_t c);
      lead_of = (c[15:12] != 4'h0) ? 2'h3 : (c[11:8] != 4'h0) ? 2'h2 : (c[7:4] != 4'h0) ? 2'h1 : 2'h0;
   endfunction

   ////////////////////////////////////////////////////////////////
   sil_fl_state_t st_r; // sequencer state
   logic [1:0] dig_r; // digit being shown
   logic [3:0] left_r; // flashes still to give
   logic [3:0] wait_r; // pause units left
   wire [1:0] lead = lead_of(code);
   wire [1:0] dig_dn = 2'(dig_r - 2'h1);

   // one step per tick; en low parks the led dark
   always_ff @(posedge clk) begin
      if (!nrst || !en) begin
         st_r <= FL_IDLE;
         led <= 1'h0;
         dig_r <= 2'h0;
         left_r <= 4'h0;
         wait_r <= 4'h0;
      end else if (tick) begin
         case (st_r)
            FL_ON: begin // equal-length on and off phases
               led <= 1'h0;
               left_r <= 4'(left_r - 4'h1);
               st_r <= FL_OFF;
            end
            FL_OFF: begin
               if (left_r != 4'h0) begin
                  led <= 1'h1;
                  st_r <= FL_ON;
               end else if (dig_r != 2'h0) begin // pause between digits
                  dig_r <= dig_dn;
                  left_r <= flashes_of(digit_of(code, dig_dn));
                  wait_r <= `SIL_GAP_UNITS;
                  st_r <= FL_GAP;
               end else begin // longer pause before repeat
                  wait_r <= `SIL_REST_UNITS;
                  st_r <= FL_REST;
               end
            end
            FL_GAP: begin
               if (wait_r == 4'h1) begin
                  led <= 1'h1;
                  st_r <= FL_ON;
               end else begin
                  wait_r <= 4'(wait_r - 4'h1);
               end
            end
            FL_IDLE, FL_REST: begin
               if (st_r == FL_IDLE || wait_r == 4'h1) begin // restart whole code
                  dig_r <= lead;
                  left_r <= flashes_of(digit_of(code, lead));
                  led <= 1'h1;
                  st_r <= FL_ON;
               end else begin
                  wait_r <= 4'(wait_r - 4'h1);
               end
            end
            default: st_r <= FL_IDLE;
         endcase
      end
   end
endmodule // sil_flash

// file: dv/sil_panel.sv
`timescale 1ns/1ns
// front panel model: momentary switches as a finger would press them
module sil_panel (
   input wire logic clk,
   input wire logic press_reset,
   input wire logic press_exer,
   output logic reset_switch,
   output logic exer_switch
);
   logic [3:0] rst_cnt_r = 4'h0; // reset switch hold count
   logic [3:0] exer_cnt_r = 4'h0; // exerciser switch hold count
   ////////////////////////////////////////////////////////////////////////
   // hold each press eight cycles so it outlives the input synchronisers
   always @(posedge clk) begin
      rst_cnt_r <= press_reset ? 4'h8 : rst_cnt_r - {3'h0, rst_cnt_r != 4'h0};
      exer_cnt_r <= press_exer ? 4'h8 : exer_cnt_r - {3'h0, exer_cnt_r != 4'h0};
   end
   assign reset_switch = rst_cnt_r != 4'h0;
   assign exer_switch = exer_cnt_r != 4'h0;
endmodule // sil_panel

// file: dv/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got %h", $time, a); end end
module tb_top;
   logic clk, nrst, rd_en, wr_en, pr_rst, pr_exer, rst_sw, exer_sw, p;
   logic [13:0] iv; // level inputs, see port map below
   logic [5:0] addr;
   logic [31:0] wdata, d;
   wire [31:0] rdata;
   wire wait_req, pend, allow;
   wire [9:0] secs;
   wire [10:0] lmp; // all lamps, status in bit 0
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int q[$]; // flash groups, 0 marks a long rest
   int dk, cnt, go;
   ////////////////////////////////////////////////////////////////////////
   sil_top #(.HALF_SEC_CYC(20)) DUT (.CLK(clk), .NRST(nrst), .ELEV_PRETRANSFER(iv[0]), .SRC1_GOOD(iv[1]),
      .SRC2_GOOD(iv[2]), .START_A_CMD(iv[3]), .START_A_DELAY(iv[4]), .START_B_CMD(iv[5]), .START_B_DELAY(iv[6]),
      .RETRANSFER_RELAY(iv[7]), .RETRANSFER_DELAY(iv[8]), .TRANSFER_RELAY(iv[9]), .FORWARD_TRANSFER_DELAY(iv[10]),
      .INPHASE_ACTIVE(iv[11]), .NEUTRAL_HOLD_DELAY(iv[12]), .EXER_PERIOD(iv[13]), .EXER_SWITCH(exer_sw),
      .RESET_SWITCH(rst_sw), .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .LED_STATUS(lmp[0]), .SOURCE_ONE_OK_LAMP(lmp[1]),
      .SOURCE_TWO_OK_LAMP(lmp[2]), .LED_START_A(lmp[3]), .LED_START_B(lmp[4]), .LED_RETRANSFER(lmp[5]),
      .LED_TRANSFER(lmp[6]), .LED_SYNC(lmp[7]), .LED_NEUTRAL(lmp[8]), .LED_EXER(lmp[9]), .ASTERISK(lmp[10]),
      .PEND_ACTIVE(pend), .PEND_SECS(secs), .EXER_ALLOW(allow));
   sil_panel panel (.clk(clk), .press_reset(pr_rst), .press_exer(pr_exer), .reset_switch(rst_sw),
      .exer_switch(exer_sw));
   ////////////////////////////////////////////////////////////////////////
   // verdict, reached from the main sequence or the timeout
   task test_done;
      if (n_fail == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one bus access; request held until waitrequest is seen low
   task bus(input logic w, input logic [5:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= w;
      rd_en <= !w;
      @(posedge clk);
      while (wait_req !== 1'b0) @(posedge clk);
      d = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask
   // one switch press on the panel model, then let it settle
   task press(input logic r);
      @(posedge clk);
      pr_rst <= r;
      pr_exer <= !r;
      @(posedge clk);
      pr_rst <= 1'b0;
      pr_exer <= 1'b0;
      repeat (14) @(posedge clk);
   endtask
   // count lamp toggles over 80 cycles; 2 is half hertz, 4 is one second
   task lamp(input int i, input int e, input logic lv);
      int n;
      n = 0;
      repeat (5) @(posedge clk);
      p = lmp[i];
      repeat (80) begin
         @(posedge clk);
         if (lmp[i] !== p) n++;
         p = lmp[i];
      end
      `CHK(n, e)
      if (e == 0) `CHK(p, lv)
   endtask
   ////////////////////////////////////////////////////////////////////////
   // 50 ns clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // hang guard, well above the expected run of about 10k cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done;
      end
   end
   // main sequence
   initial begin
      nrst = 1'b0;
      iv = '0;
      addr = '0;
      wdata = '0;
      rd_en = 1'b0;
      wr_en = 1'b0;
      pr_rst = 1'b0;
      pr_exer = 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      bus(0, 6'h10, 0); `CHK(d, 32'h0000_000A)
      bus(0, 6'h20, 0); `CHK(d, 32'h0000_0000)
      bus(0, 6'h3C, 0); `CHK(d, 32'h0000_0000)
      lamp(0, 2, 0);
      iv[1] <= 1'b1;
      lamp(1, 0, 1);
      lamp(2, 0, 0);
      iv[1] <= 1'b0;
      iv[2] <= 1'b1;
      lamp(1, 0, 0);
      lamp(2, 0, 1);
      // start B stays dark outside genset mode
      iv[5] <= 1'b1;
      lamp(4, 0, 0);
      bus(1, 6'h00, 32'h0000_0002);
      // steady on command, blink on delay, delay wins
      for (int k = 0; k < 4; k++) begin
         iv[3 + 2 * k] <= 1'b1;
         lamp(3 + k, 0, 1);
         iv[4 + 2 * k] <= 1'b1;
         lamp(3 + k, 2, 0);
         iv[3 + 2 * k] <= 1'b0;
         iv[4 + 2 * k] <= 1'b0;
      end
      // sync blink ends by itself after its limit
      iv[11] <= 1'b1;
      lamp(7, 4, 0);
      repeat (4800) @(posedge clk);
      lamp(7, 0, 0);
      iv[11] <= 1'b0;
      iv[12] <= 1'b1;
      lamp(8, 2, 0);
      iv[12] <= 1'b0;
      // exerciser: off, toggled on by switch, off again by bus
      iv[13] <= 1'b1;
      lamp(9, 0, 0);
      `CHK(allow, 1'b0)
      press(1'b0);
      lamp(9, 2, 0);
      `CHK(allow, 1'b1)
      iv[13] <= 1'b0;
      lamp(9, 0, 1);
      bus(1, 6'h00, 32'h0000_0002);
      lamp(9, 0, 0);
      // fault 103 active; a second raise is dropped
      bus(1, 6'h08, 32'h0001_0103);
      bus(1, 6'h08, 32'h0000_0441);
      bus(0, 6'h0C, 0); `CHK(d, 32'h8001_0103)
      lamp(10, 2, 0);
      // group flashes by dark runs: >30 cycles between digits, >120 at the rest
      dk = 0;
      cnt = 0;
      go = 0;
      p = lmp[0];
      repeat (2000) begin
         @(posedge clk);
         if (lmp[0] === 1'b1 && p !== 1'b1) begin
            if (dk > 30) begin
               if (go) q.push_back(cnt);
               if (dk > 120 && go) q.push_back(0);
               if (dk > 120) go = 1;
               cnt = 0;
            end
            cnt++;
            dk = 0;
         end else if (lmp[0] !== 1'b1) dk++;
         p = lmp[0];
      end
      `CHK(q[0], 1)
      `CHK(q[1], 10)
      `CHK(q[2], 3)
      `CHK(q[3], 0)
      // acknowledge, heartbeat returns, event logged
      press(1'b1);
      bus(0, 6'h0C, 0); `CHK(d[31], 1'b0)
      lamp(0, 2, 0);
      bus(1, 6'h18, 0);
      bus(0, 6'h1C, 0); `CHK(d, 32'h8001_0103)
      // fifty more events overflow the store
      for (int i = 1; i <= 50; i++) begin
         bus(1, 6'h08, 32'h0000_1000 | ((i / 10) << 4) | (i % 10));
         press(1'b1);
      end
      bus(0, 6'h20, 0); `CHK(d, 32'h0000_0032)
      bus(0, 6'h1C, 0); `CHK(d, 32'h8000_1050)
      bus(1, 6'h18, 32'h0000_0031);
      bus(0, 6'h1C, 0); `CHK(d, 32'h8000_1001)
      bus(1, 6'h18, 32'h0000_0032);
      bus(0, 6'h1C, 0); `CHK(d[31], 1'b0)
      // transfer pending of three seconds
      bus(1, 6'h10, 32'h0000_0003);
      iv[0] <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(pend, 1'b1)
      `CHK(secs == 10'h003 || secs == 10'h002, 1'b1)
      bus(0, 6'h14, 0); `CHK(d[31], 1'b1)
      repeat (130) @(posedge clk);
      `CHK(pend, 1'b0)
      `CHK(secs, 10'h000)
      test_done;
   end
endmodule // tb_top
